// ===== dffc_consts.svh
// Constants for the flush and format command block.
// Assumes an APB slave at 20 MHz with 32-bit aligned registers.
`ifndef DFFC_CONSTS_SVH
`define DFFC_CONSTS_SVH
`define DFFC_A_DATA 8'h00
`define DFFC_A_FEAT 8'h04
`define DFFC_A_SCNT 8'h08
`define DFFC_A_SNUM 8'h0C
`define DFFC_A_CYLL 8'h10
`define DFFC_A_CYLH 8'h14
`define DFFC_A_DHS 8'h18
`define DFFC_A_CMD 8'h1C
`define DFFC_A_ERR 8'h20
`define DFFC_A_CTL 8'h24
`define DFFC_OP_FLUSH_EXT 8'hEA
`define DFFC_OP_FMT_TRACK 8'h50
`define DFFC_OP_FMT_UNIT 8'hF7
`define DFFC_OP_ERASE_PREP 8'hF3
`define DFFC_DHS_LBA_BIT 6
`define DFFC_CTL_HOB_BIT 7
`define DFFC_ERR_ABT_BIT 2
`define DFFC_ERR_IDN_BIT 4
`define DFFC_ST_BSY_BIT 7
`define DFFC_ST_RDY_BIT 6
`define DFFC_ST_DSC_BIT 4
`define DFFC_ST_DRQ_BIT 3
`define DFFC_ST_ERR_BIT 0
`define DFFC_SECT_PER_TRK 28'h000003F
`define DFFC_HEADS 28'h0000010
`define DFFC_NATIVE_MAX_LBA 28'h0FFFFFF
`define DFFC_TABLE_WORDS 8'h80
`define DFFC_DHS_RESET 8'hA0
`endif

// ===== dffc_pkg.sv
// Types for the flush and format command block.
// Assumes dffc_consts.svh is on the include path.
`default_nettype none
package dffc_pkg;
	// Media engine operation codes
	typedef enum logic [1:0] {
		MED_FLUSH,
		MED_ZERO,
		MED_MERGE
	} dffc_med_op_t;
	// Request handed to the media engine
	typedef struct packed {
		dffc_med_op_t op;
		logic [27:0] lba;
		logic [27:0] count;
	} dffc_med_req_t;
	// Command sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TABLE,
		ST_CALC,
		ST_MEDIA,
		ST_ZERO_UNIT,
		ST_DONE
	} dffc_state_t;
endpackage
`default_nettype wire

// ===== dffc_top.sv
// Command block for extended flush, track format and unit format.
// Assumes an APB master and a media engine that answers med_done.
`timescale 1ns/1ns
`default_nettype none
`include "dffc_consts.svh"
module dffc_top
	import dffc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Media engine
	output dffc_med_req_t med_req,
	output logic med_valid,
	input wire logic med_done,
	input wire logic med_err,
	// Reduced capacity limit set elsewhere
	input wire logic [27:0] max_lba_limit
);
	// ----------------------------------------
	// Taskfile
	// ----------------------------------------
	logic [7:0] feat_reg [2];
	logic [7:0] scnt_reg [2];
	logic [7:0] snum_reg [2];
	logic [7:0] cyll_reg [2];
	logic [7:0] cylh_reg [2];
	logic [7:0] drive_head_select_reg;
	logic [7:0] error_reason_reg;
	logic [7:0] ctl_reg;
	logic err_st_reg;
	logic prep_armed_reg;
	logic [7:0] tbl_cnt_reg;
	dffc_state_t state_reg;
	logic [27:0] lba_next;
	logic [27:0] trk_start;
	logic in_range;
	logic wr_acc;
	logic rd_setup;
	logic busy;
	logic drq;
	logic high_order_readback;
	logic lba_mode;
	logic cmd_wr;
	logic data_wr;
	logic [7:0] command_status;
	logic [7:0] rd_byte;
	logic mapped;

	assign wr_acc = clk_en & psel & penable & pwrite;
	assign rd_setup = clk_en & psel & ~penable & ~pwrite;
	assign busy = (state_reg != ST_IDLE);
	assign drq = (state_reg == ST_TABLE);
	assign high_order_readback = ctl_reg[`DFFC_CTL_HOB_BIT];
	assign lba_mode = drive_head_select_reg[`DFFC_DHS_LBA_BIT];
	assign cmd_wr = wr_acc & (paddr == `DFFC_A_CMD) & ~busy;
	assign data_wr = wr_acc & (paddr == `DFFC_A_DATA);
	assign mapped = (paddr <= `DFFC_A_CTL) & (paddr[1:0] == 2'b00);

	always_comb begin
		command_status = 8'h00;
		command_status[`DFFC_ST_BSY_BIT] = busy & ~drq;
		command_status[`DFFC_ST_RDY_BIT] = 1'b1;
		command_status[`DFFC_ST_DSC_BIT] = 1'b1;
		command_status[`DFFC_ST_DRQ_BIT] = drq;
		command_status[`DFFC_ST_ERR_BIT] = err_st_reg;
	end

	// ----------------------------------------
	// Taskfile writes
	// ----------------------------------------
	// Each write pushes current to previous, giving the 48-bit view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				feat_reg[i] <= 8'h00;
				scnt_reg[i] <= 8'h00;
			end
		end else if (wr_acc && !busy) begin
			if (paddr == `DFFC_A_FEAT) begin
				feat_reg[1] <= feat_reg[0];
				feat_reg[0] <= pwdata[7:0];
			end
			if (paddr == `DFFC_A_SCNT) begin
				scnt_reg[1] <= scnt_reg[0];
				scnt_reg[0] <= pwdata[7:0];
			end
		end
	end

	// Address regs are also written back after an LBA track format
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				snum_reg[i] <= 8'h00;
				cyll_reg[i] <= 8'h00;
				cylh_reg[i] <= 8'h00;
			end
		end else if (clk_en) begin
			if (state_reg == ST_DONE && lba_mode && !err_st_reg) begin
				snum_reg[0] <= trk_start[7:0];
				cyll_reg[0] <= trk_start[15:8];
				cylh_reg[0] <= trk_start[23:16];
			end else if (wr_acc && !busy) begin
				if (paddr == `DFFC_A_SNUM) begin
					snum_reg[1] <= snum_reg[0];
					snum_reg[0] <= pwdata[7:0];
				end
				if (paddr == `DFFC_A_CYLL) begin
					cyll_reg[1] <= cyll_reg[0];
					cyll_reg[0] <= pwdata[7:0];
				end
				if (paddr == `DFFC_A_CYLH) begin
					cylh_reg[1] <= cylh_reg[0];
					cylh_reg[0] <= pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_head_select_reg <= `DFFC_DHS_RESET;
		end else if (clk_en) begin
			if (state_reg == ST_DONE && lba_mode && !err_st_reg) begin
				drive_head_select_reg[3:0] <= trk_start[27:24];
			end else if (wr_acc && !busy && paddr == `DFFC_A_DHS) begin
				drive_head_select_reg <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= 8'h00;
		end else if (wr_acc && paddr == `DFFC_A_CTL) begin
			ctl_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Track address
	// ----------------------------------------
	// Divide by track length is costly but only runs once per command
	always_comb begin
		if (lba_mode) begin
			lba_next = {drive_head_select_reg[3:0], cylh_reg[0],
				cyll_reg[0], snum_reg[0]};
		end else begin
			lba_next = 28'(({12'h000, cylh_reg[0], cyll_reg[0]}
				* `DFFC_HEADS + 28'(drive_head_select_reg[3:0]))
				* `DFFC_SECT_PER_TRK);
		end
	end

	assign in_range = (lba_next <= max_lba_limit);

	// Whole track holding the block, always laid out 1:1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trk_start <= 28'h0000000;
		end else if (clk_en && state_reg == ST_CALC) begin
			trk_start <= lba_next - (lba_next % `DFFC_SECT_PER_TRK);
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else if (clk_en) begin
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_wr) begin
						if (pwdata[7:0] == `DFFC_OP_FLUSH_EXT) begin
							state_reg <= ST_MEDIA;
						end else if (pwdata[7:0] == `DFFC_OP_FMT_TRACK) begin
							state_reg <= ST_TABLE;
						end else if (pwdata[7:0] == `DFFC_OP_FMT_UNIT
							&& prep_armed_reg) begin
							state_reg <= ST_MEDIA;
						end
					end
				end
				ST_TABLE: begin
					// Table contents are counted, never stored
					if (data_wr && tbl_cnt_reg == `DFFC_TABLE_WORDS - 8'h01) begin
						state_reg <= ST_CALC;
					end
				end
				ST_CALC: begin
					if (in_range) begin
						state_reg <= ST_MEDIA;
					end else begin
						state_reg <= ST_DONE;
					end
				end
				ST_MEDIA: begin
					if (med_done && med_req.op == MED_MERGE && !med_err) begin
						state_reg <= ST_ZERO_UNIT;
					end else if (med_done) begin
						state_reg <= ST_DONE;
					end
				end
				ST_ZERO_UNIT: begin
					if (med_done) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_cnt_reg <= 8'h00;
		end else if (clk_en) begin
			if (state_reg != ST_TABLE) begin
				tbl_cnt_reg <= 8'h00;
			end else if (data_wr) begin
				tbl_cnt_reg <= tbl_cnt_reg + 8'h01;
			end
		end
	end

	// Only the command right after erase-prepare may format the unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prep_armed_reg <= 1'b0;
		end else if (cmd_wr) begin
			prep_armed_reg <= (pwdata[7:0] == `DFFC_OP_ERASE_PREP);
		end
	end

	// ----------------------------------------
	// Media request
	// ----------------------------------------
	// No verify pass follows the zero write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			med_req <= '0;
			med_valid <= 1'b0;
		end else if (clk_en) begin
			if (cmd_wr && pwdata[7:0] == `DFFC_OP_FLUSH_EXT) begin
				med_req <= '{MED_FLUSH, 28'h0000000, 28'h0000000};
				med_valid <= 1'b1;
			end else if (cmd_wr && pwdata[7:0] == `DFFC_OP_FMT_UNIT
				&& prep_armed_reg) begin
				med_req <= '{MED_MERGE, 28'h0000000, 28'h0000000};
				med_valid <= 1'b1;
			end else if (state_reg == ST_CALC && in_range) begin
				med_req <= '{MED_ZERO, lba_next
					- (lba_next % `DFFC_SECT_PER_TRK),
					`DFFC_SECT_PER_TRK};
				med_valid <= 1'b1;
			end else if (state_reg == ST_MEDIA && med_done
				&& med_req.op == MED_MERGE && !med_err) begin
				med_req <= '{MED_ZERO, 28'h0000000,
					`DFFC_NATIVE_MAX_LBA + 28'h0000001};
				med_valid <= 1'b1;
			end else if (med_done) begin
				med_valid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Error and status
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_reason_reg <= 8'h00;
			err_st_reg <= 1'b0;
		end else if (clk_en) begin
			if (cmd_wr) begin
				error_reason_reg <= 8'h00;
				err_st_reg <= 1'b0;
				if (pwdata[7:0] == `DFFC_OP_FMT_UNIT && !prep_armed_reg) begin
					error_reason_reg[`DFFC_ERR_ABT_BIT] <= 1'b1;
					err_st_reg <= 1'b1;
				end
			end else if (state_reg == ST_CALC && !in_range) begin
				error_reason_reg[`DFFC_ERR_ABT_BIT] <= 1'b1;
				err_st_reg <= 1'b1;
			end else if (busy && med_done && med_err) begin
				error_reason_reg[`DFFC_ERR_IDN_BIT] <= 1'b1;
				err_st_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	// Read data is registered in setup, so access needs no wait state
	always_comb begin
		rd_byte = 8'h00;
		unique case (paddr)
			`DFFC_A_FEAT: rd_byte = feat_reg[high_order_readback];
			`DFFC_A_SCNT: rd_byte = scnt_reg[high_order_readback];
			`DFFC_A_SNUM: rd_byte = snum_reg[high_order_readback];
			`DFFC_A_CYLL: rd_byte = cyll_reg[high_order_readback];
			`DFFC_A_CYLH: rd_byte = cylh_reg[high_order_readback];
			`DFFC_A_DHS: rd_byte = drive_head_select_reg;
			`DFFC_A_CMD: rd_byte = command_status;
			`DFFC_A_ERR: rd_byte = error_reason_reg;
			`DFFC_A_CTL: rd_byte = ctl_reg;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= {24'h000000, rd_byte};
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_flush_start: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && pwdata[7:0] == `DFFC_OP_FLUSH_EXT
		|=> med_valid && med_req.op == MED_FLUSH && busy)
		else $error("flush command did not start media flush");

	a_flush_hold: assert property (@(posedge pclk) disable iff (!presetn)
		med_valid && med_req.op == MED_FLUSH && !med_done |=> busy)
		else $error("busy dropped before flush finished");

	a_track_len: assert property (@(posedge pclk) disable iff (!presetn)
		med_valid && med_req.op == MED_ZERO && state_reg == ST_MEDIA
		|-> med_req.count == `DFFC_SECT_PER_TRK
		&& (med_req.lba % `DFFC_SECT_PER_TRK) == 28'h0000000)
		else $error("track format not one aligned track");

	a_range_abort: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_reg == ST_CALC && !in_range
		|=> error_reason_reg[`DFFC_ERR_ABT_BIT] && err_st_reg
		##1 state_reg == ST_IDLE)
		else $error("out of range track not aborted");

	a_unit_span: assert property (@(posedge pclk) disable iff (!presetn)
		med_valid && state_reg == ST_ZERO_UNIT
		|-> med_req.lba == 28'h0000000
		&& med_req.count == `DFFC_NATIVE_MAX_LBA + 28'h0000001)
		else $error("unit format span wrong");

	a_unit_order: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_reg == ST_MEDIA && med_req.op == MED_MERGE
		&& med_done && !med_err |=> state_reg == ST_ZERO_UNIT && med_valid)
		else $error("zero pass did not follow defect merge");

	a_unit_noprep: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && pwdata[7:0] == `DFFC_OP_FMT_UNIT && !prep_armed_reg
		|=> !busy && error_reason_reg[`DFFC_ERR_ABT_BIT] && err_st_reg)
		else $error("unprepared unit format not aborted");

	a_unit_nodrq: assert property (@(posedge pclk) disable iff (!presetn)
		med_valid && med_req.op != MED_ZERO |-> !drq)
		else $error("data request during unit format");

	a_lba_return: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_reg == ST_DONE && lba_mode && !err_st_reg
		|=> snum_reg[0] == $past(trk_start[7:0])
		&& drive_head_select_reg[3:0] == $past(trk_start[27:24]))
		else $error("current LBA not returned");

	a_busy_clear: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state_reg == ST_DONE |=> !busy)
		else $error("busy not cleared on completion");

endmodule // dffc_top
`default_nettype wire

// ===== dffc_media_model.sv
// Behavioural media engine facing the command block.
// Assumes one request at a time, held by med_valid until med_done.
`timescale 1ns/1ns
`default_nettype none
module dffc_media_model
	import dffc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request side
	input wire dffc_med_req_t med_req,
	input wire logic med_valid,
	output logic med_done,
	output logic med_err,
	// Bench knobs
	input wire logic [7:0] lat,
	input wire logic fail
);
	// ----------------------------------------
	// Completion timing
	// ----------------------------------------
	logic [7:0] cnt;
	logic hold;
	dffc_med_req_t log_q[$];
	// Hold skips the cycle after done, when med_valid still shows the old job
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			hold <= 1'b0;
			med_done <= 1'b0;
			med_err <= 1'b0;
		end else begin
			med_done <= 1'b0;
			med_err <= 1'b0;
			if (hold) begin
				hold <= 1'b0;
			end else if (med_valid) begin
				if (cnt == lat) begin
					med_done <= 1'b1;
					med_err <= fail;
					log_q.push_back(med_req);
					cnt <= 8'h00;
					hold <= 1'b1;
				end else begin
					cnt <= cnt + 8'h01;
				end
			end
		end
	end
endmodule // dffc_media_model
`default_nettype wire

// ===== disk_flush_format_commands_test.sv
// Self-checking bench for the flush and format command block.
// Assumes the package, constants header and media model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "dffc_consts.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module disk_flush_format_commands_test
	import dffc_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dffc_med_req_t med_req;
	logic med_valid;
	logic med_done;
	logic med_err;
	logic [27:0] max_lba_limit = 28'h0FFFFFF;
	logic [7:0] lat = 8'h00;
	logic fail = 1'b0;
	logic [31:0] q;
	logic se;
	int miscompares = 0;
	int samples_checked = 0;

	always #25 pclk = ~pclk;

	dffc_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.med_req(med_req), .med_valid(med_valid), .med_done(med_done),
		.med_err(med_err), .max_lba_limit(max_lba_limit));

	dffc_media_model MED (.pclk(pclk), .presetn(presetn), .med_req(med_req),
		.med_valid(med_valid), .med_done(med_done), .med_err(med_err),
		.lat(lat), .fail(fail));

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic apb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// Polls status rather than counting cycles: the media latency varies
	task automatic wait_idle;
		for (int i = 0; i < 400; i++) begin
			rd(`DFFC_A_CMD);
			if ((q & 32'h88) === 32'h0) break;
		end
	endtask

	task automatic expect_req(dffc_med_op_t op, logic chk, logic [27:0] l,
		logic [27:0] c);
		dffc_med_req_t r;
		`CHK("req seen", 1'b1, MED.log_q.size() > 0)
		r = '0;
		if (MED.log_q.size() > 0) r = MED.log_q.pop_front();
		`CHK("req op", op, r.op)
		if (chk) begin
			`CHK("req lba", l, r.lba)
			`CHK("req count", c, r.count)
		end
	endtask

	task automatic conclude;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(`DFFC_A_CMD);
		`CHK("status", 32'h50, q)
		rd(`DFFC_A_DHS);
		`CHK("dhs", 32'hA0, q)
		rd(8'h28);
		`CHK("unmapped err", 1'b1, se)
		$display("test reset done");
	endtask

	task automatic t_flush;
		lat = 8'h14;
		wr(`DFFC_A_CMD, `DFFC_OP_FLUSH_EXT);
		rd(`DFFC_A_CMD);
		`CHK("busy", 32'hD0, q)
		wait_idle();
		`CHK("status", 32'h50, q)
		expect_req(MED_FLUSH, 1'b0, 28'h0, 28'h0);
		fail = 1'b1;
		lat = 8'h00;
		wr(`DFFC_A_CMD, `DFFC_OP_FLUSH_EXT);
		wait_idle();
		fail = 1'b0;
		`CHK("status", 32'h51, q)
		rd(`DFFC_A_ERR);
		`CHK("error", 32'h10, q)
		expect_req(MED_FLUSH, 1'b0, 28'h0, 28'h0);
		$display("test flush done");
	endtask

	task automatic t_prev;
		wr(`DFFC_A_SNUM, 8'h11);
		wr(`DFFC_A_SNUM, 8'h22);
		wr(`DFFC_A_CTL, 8'h80);
		rd(`DFFC_A_SNUM);
		`CHK("prev snum", 32'h11, q)
		wr(`DFFC_A_CTL, 8'h00);
		rd(`DFFC_A_SNUM);
		`CHK("cur snum", 32'h22, q)
		$display("test previous done");
	endtask

	// Writes made while the clock enable is low must leave no trace
	task automatic t_hold;
		@(posedge pclk);
		clk_en <= 1'b0;
		wr(`DFFC_A_CMD, `DFFC_OP_FLUSH_EXT);
		wr(`DFFC_A_SNUM, 8'h5A);
		clk_en <= 1'b1;
		rd(`DFFC_A_CMD);
		`CHK("frozen status", 32'h51, q)
		rd(`DFFC_A_SNUM);
		`CHK("frozen snum", 32'h22, q)
		`CHK("frozen media", 0, MED.log_q.size())
		$display("test clock enable done");
	endtask

	task automatic t_unit_noprep;
		wr(`DFFC_A_CMD, `DFFC_OP_FMT_UNIT);
		rd(`DFFC_A_ERR);
		`CHK("abort", 32'h04, q)
		rd(`DFFC_A_CMD);
		`CHK("status", 32'h51, q)
		`CHK("no media", 0, MED.log_q.size())
		$display("test unit unprepared done");
	endtask

	task automatic track(input logic lm, input logic [27:0] l);
		logic [27:0] st;
		logic oor;
		st = lm ? l - l % `DFFC_SECT_PER_TRK :
			(28'(l[23:8]) * `DFFC_HEADS + 28'(l[27:24])) * `DFFC_SECT_PER_TRK;
		oor = lm && (l > max_lba_limit);
		wr(`DFFC_A_SNUM, l[7:0]);
		wr(`DFFC_A_CYLL, l[15:8]);
		wr(`DFFC_A_CYLH, l[23:16]);
		wr(`DFFC_A_DHS, 8'hA0 | {1'b0, lm, 2'b00, l[27:24]});
		wr(`DFFC_A_CMD, `DFFC_OP_FMT_TRACK);
		rd(`DFFC_A_CMD);
		`CHK("drq", 32'h58, q)
		// Table contents are junk on purpose; the layout must not change
		for (int i = 0; i < 128; i++) wr(`DFFC_A_DATA, 8'(i * 7));
		wait_idle();
		if (oor) begin
			rd(`DFFC_A_ERR);
			`CHK("abort", 32'h04, q)
			`CHK("no media", 0, MED.log_q.size())
		end else begin
			`CHK("status", 32'h50, q)
			expect_req(MED_ZERO, 1'b1, st, `DFFC_SECT_PER_TRK);
		end
		if (lm && !oor) begin
			rd(`DFFC_A_SNUM);
			`CHK("lba 7:0", {24'h0, st[7:0]}, q)
			rd(`DFFC_A_CYLL);
			`CHK("lba 15:8", {24'h0, st[15:8]}, q)
			rd(`DFFC_A_CYLH);
			`CHK("lba 23:16", {24'h0, st[23:16]}, q)
			rd(`DFFC_A_DHS);
			`CHK("lba 27:24", st[27:24], q[3:0])
		end
		$display("test track done");
	endtask

	task automatic t_unit;
		max_lba_limit = 28'h0001000;
		lat = 8'h03;
		wr(`DFFC_A_FEAT, 8'h11);
		wr(`DFFC_A_CMD, `DFFC_OP_ERASE_PREP);
		wr(`DFFC_A_CMD, `DFFC_OP_FMT_UNIT);
		rd(`DFFC_A_CMD);
		`CHK("busy no drq", 32'hD0, q)
		wait_idle();
		`CHK("status", 32'h50, q)
		expect_req(MED_MERGE, 1'b0, 28'h0, 28'h0);
		expect_req(MED_ZERO, 1'b1, 28'h0, 28'h1000000);
		$display("test unit done");
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_flush();
		t_prev();
		t_hold();
		t_unit_noprep();
		lat = 8'h05;
		track(1'b1, 28'h0001234);
		track(1'b0, 28'h3000201);
		max_lba_limit = 28'h0001000;
		track(1'b1, 28'h0001234);
		t_unit();
		conclude();
	end

	// Limit sized from host-chosen unit format timeout
	initial begin
		#(50 * 20000);
		miscompares++;
		conclude();
	end
endmodule // disk_flush_format_commands_test
`default_nettype wire
